//--- rtfr_regs.sv
/*
  Register group for partial bit framing and antenna driver control
  of a contactless reader: timer and CRC views, bit framing fields,
  modulator source, carrier enables and driver conductances.
  Assumes the timer, CRC engine, encoder and receiver live elsewhere,
  all inputs synchronous to core_clk, and rst asynchronous high.
  The host keeps reserved register bits at their reset values;
  framing bits 7 and 3 are not stored and always read as zero.
  Pin levels and conductance are registered, so they follow the
  register contents and modulator inputs by one clock.
  End of reception or transmission clears its framing field and
  wins over a host write in the same cycle.
  Reads of the CRC bytes are only meaningful while the
  completion flag is set; the high byte means nothing for an
  8-bit CRC, which crc_high_valid reports.
  The carrier phase input is sampled like the modulator inputs.

  // Overview of operation
  // - Timer view reads live counter value
  // - CRC low byte read at 0x0d
  // - CRC high byte read at 0x0e
  // - High byte undefined for 8-bit CRC
  // - Receive alignment sets first stored bit
  // - Alignment seven spills second bit onward
  // - Alignment cleared when reception ends
  // - Last bits count; zero sends all
  // - Last bits cleared when transmission ends
  // - Source field picks modulator input
  // - Force bit gives full depth modulation
  // - Forced mode ignores modulation conductance
  // - Second pin inverted when bit is zero
  // - Continuous wave bit stops second modulation
  // - Second enable gates second pin carrier
  // - First enable gates first pin carrier
  // - Carrier conductance sets unmodulated drive
  // - Modulation conductance sets modulated drive
*/
`timescale 1ns/100ps
`include "rtfr_consts.svh"

module rtfr_regs
(
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst,

  // Host register port
  input  wire rtfr_pkg::rtfr_req_type host_req,
  output logic                  [7:0] host_rdata,

  // Timer and CRC views
  input  wire logic             [7:0] timer_count,
  input  wire logic            [15:0] crc_value,
  input  wire logic                   crc_completion_flag,
  input  wire logic                   crc_eight_bit,

  // Framing events
  input  wire logic                   reception_done,
  input  wire logic                   transmission_done,

  // Modulator and carrier inputs
  input  wire logic                   encoder_data,
  input  wire logic                   external_modulation_input,
  input  wire logic                   carrier_clk_phase,

  // Framing fields
  output logic                  [2:0] receive_alignment,
  output logic                  [2:0] transmit_last_bits,

  // CRC validity
  output logic                        crc_result_valid,
  output logic                        crc_high_valid,

  // Antenna driver
  output rtfr_pkg::rtfr_drive_type    drive
);

  import rtfr_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [2:0]     receive_alignment_q;
  logic [2:0]     transmit_last_bits_q;
  logic [7:0]     partial_bit_framing;
  logic [7:0]     transmit_pin_control_q;
  logic [7:0]     carrier_drive_conductance_q;
  logic [7:0]     modulation_drive_conductance_q;

  // Driver bundle, next and registered
  rtfr_drive_type drive_d;
  rtfr_drive_type drive_q;

  // Decoded control fields
  rtfr_src_type   modulator_source;
  logic           force_full_ask;
  logic           second_driver_invert;
  logic           second_driver_continuous_wave;
  logic           second_driver_carrier_enable;
  logic           first_driver_carrier_enable;
  logic [5:0]     carrier_conductance_level;
  logic [5:0]     modulation_conductance_level;
  logic           modulator_in;
  logic           second_modulated;
  logic           forced_pause;
  logic           first_pin_d;
  logic           second_pin_d;
  logic [5:0]     conductance_d;

  // Write strobes, one per register
  logic           framing_wr;
  logic           txctrl_wr;
  logic           cw_cond_wr;
  logic           mod_cond_wr;

  // Write decode helper
  function automatic logic hit(input rtfr_req_type r, input logic [5:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  // Modulating while full depth is forced
  function automatic logic pause_forced(input logic m, input logic f);
    pause_forced = m && f;
  endfunction

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign framing_wr  = hit(host_req, `RTFR_ADDR_FRAMING);
  assign txctrl_wr   = hit(host_req, `RTFR_ADDR_TXCTRL);
  assign cw_cond_wr  = hit(host_req, `RTFR_ADDR_CW_COND);
  assign mod_cond_wr = hit(host_req, `RTFR_ADDR_MOD_COND);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Receive alignment; end of reception wins over a host write
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      receive_alignment_q <= `RTFR_RST_ALIGN;
    else if (reception_done)
      receive_alignment_q <= 3'h0;
    else if (framing_wr)
      receive_alignment_q <= host_req.wdata[`RTFR_ALIGN_HI:`RTFR_ALIGN_LO];
  end

  // Transmit last bits; end of transmission wins over a host write
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      transmit_last_bits_q <= `RTFR_RST_LAST;
    else if (transmission_done)
      transmit_last_bits_q <= 3'h0;
    else if (framing_wr)
      transmit_last_bits_q <= host_req.wdata[`RTFR_LAST_HI:`RTFR_LAST_LO];
  end

  // Framing image; reserved bits 7 and 3 read as zero
  assign partial_bit_framing = {1'b0, receive_alignment_q, 1'b0, transmit_last_bits_q};

  // Transmitter control register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      transmit_pin_control_q <= `RTFR_RST_TXCTRL;
    else if (txctrl_wr)
      transmit_pin_control_q <= host_req.wdata;
  end

  // Conductance registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      carrier_drive_conductance_q    <= `RTFR_RST_CW_COND;
      modulation_drive_conductance_q <= `RTFR_RST_MOD_COND;
    end
    else
    begin
      if (cw_cond_wr)
        carrier_drive_conductance_q <= host_req.wdata;
      if (mod_cond_wr)
        modulation_drive_conductance_q <= host_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  assign receive_alignment  = receive_alignment_q;
  assign transmit_last_bits = transmit_last_bits_q;
  assign modulator_source   = rtfr_src_type'(transmit_pin_control_q[`RTFR_SRC_HI:`RTFR_SRC_LO]);
  assign force_full_ask                = transmit_pin_control_q[`RTFR_FORCE_BIT];
  assign second_driver_invert          = transmit_pin_control_q[`RTFR_INV2_BIT];
  assign second_driver_continuous_wave = transmit_pin_control_q[`RTFR_CW2_BIT];
  assign second_driver_carrier_enable  = transmit_pin_control_q[`RTFR_EN2_BIT];
  assign first_driver_carrier_enable   = transmit_pin_control_q[`RTFR_EN1_BIT];
  assign carrier_conductance_level     = carrier_drive_conductance_q[`RTFR_COND_HI:0];
  assign modulation_conductance_level  = modulation_drive_conductance_q[`RTFR_COND_HI:0];

  // ----------------------------------------------------------------
  // CRC views
  // ----------------------------------------------------------------
  // CRC validity flags
  assign crc_result_valid = crc_completion_flag;
  assign crc_high_valid   = crc_completion_flag && !crc_eight_bit;

  // ----------------------------------------------------------------
  // Modulator input
  // ----------------------------------------------------------------
  // Modulator input source select
  always_comb
  begin
    unique case (modulator_source)
      RTFR_SRC_LOW:      modulator_in = 1'b0;
      RTFR_SRC_HIGH:     modulator_in = 1'b1;
      RTFR_SRC_ENCODER:  modulator_in = encoder_data;
      RTFR_SRC_EXTERNAL: modulator_in = external_modulation_input;
    endcase
  end

  // High modulator input means modulation pause
  assign second_modulated = modulator_in && !second_driver_continuous_wave;

  // Full depth pause on the first pin and conductance
  assign forced_pause = pause_forced(modulator_in, force_full_ask);

  // ----------------------------------------------------------------
  // Antenna driver
  // ----------------------------------------------------------------
  // First pin: gated carrier or constant low
  always_comb
  begin
    first_pin_d = 1'b0;
    if (first_driver_carrier_enable)
      first_pin_d = carrier_clk_phase && !forced_pause;
  end

  // Second pin: inverted when the invert bit is zero
  always_comb
  begin
    second_pin_d = 1'b0;
    if (second_driver_carrier_enable)
      second_pin_d = (carrier_clk_phase ^ !second_driver_invert)
                     && !pause_forced(second_modulated, force_full_ask);
  end

  // Conductance per phase
  always_comb
  begin
    if (forced_pause)
      conductance_d = `RTFR_COND_OFF;
    else if (modulator_in)
      conductance_d = modulation_conductance_level;
    else
      conductance_d = carrier_conductance_level;
  end

  // Driver bundle
  assign drive_d = {first_pin_d, second_pin_d, conductance_d};

  // ----------------------------------------------------------------
  // Driver outputs
  // ----------------------------------------------------------------
  // Registered driver outputs
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      drive_q <= '0;
    else
      drive_q <= drive_d;
  end

  assign drive = drive_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  rtfr_readmux u_readmux
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .rd          (host_req.rd),
    .addr        (host_req.addr),
    .timer_count (timer_count),
    .crc_value   (crc_value),
    .framing     (partial_bit_framing),
    .txctrl      (transmit_pin_control_q),
    .cw_cond     (carrier_drive_conductance_q),
    .mod_cond    (modulation_drive_conductance_q),
    .rdata       (host_rdata)
  );

endmodule

//--- rtfr_consts.svh
/*
  Offsets, field positions and reset values for the
  reader transmit framing register group.
  Assumes inclusion by bare name from the design files.
*/
`ifndef RTFR_CONSTS_SVH
`define RTFR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RTFR_ADDR_TIMER      6'h0c
`define RTFR_ADDR_CRC_LOW    6'h0d
`define RTFR_ADDR_CRC_HIGH   6'h0e
`define RTFR_ADDR_FRAMING    6'h0f
`define RTFR_ADDR_TXCTRL     6'h11
`define RTFR_ADDR_CW_COND    6'h12
`define RTFR_ADDR_MOD_COND   6'h13

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTFR_RST_FRAMING     8'h00
`define RTFR_RST_TXCTRL      8'h58
`define RTFR_RST_CW_COND     8'h3f
`define RTFR_RST_MOD_COND    8'h3f
`define RTFR_RST_ALIGN       3'h0
`define RTFR_RST_LAST        3'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RTFR_ALIGN_HI        6
`define RTFR_ALIGN_LO        4
`define RTFR_LAST_HI         2
`define RTFR_LAST_LO         0
`define RTFR_SRC_HI          6
`define RTFR_SRC_LO          5
`define RTFR_FORCE_BIT       4
`define RTFR_INV2_BIT        3
`define RTFR_CW2_BIT         2
`define RTFR_EN2_BIT         1
`define RTFR_EN1_BIT         0
`define RTFR_COND_HI         5

// ----------------------------------------------------------------
// Full modulation depth conductance (driver off)
// ----------------------------------------------------------------
`define RTFR_COND_OFF        6'h00

`endif

//--- rtfr_pkg.sv
/*
  Types for the reader transmit framing register group.
  Assumes rtfr_consts.svh is on the include path.
*/
package rtfr_pkg;

  // Modulator input source codes
  typedef enum logic [1:0]
  {
    RTFR_SRC_LOW,
    RTFR_SRC_HIGH,
    RTFR_SRC_ENCODER,
    RTFR_SRC_EXTERNAL
  } rtfr_src_type;

  // Host register port request
  typedef struct packed
  {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rtfr_req_type;

  // Driver controls towards the antenna stage
  typedef struct packed
  {
    logic       first_pin;
    logic       second_pin;
    logic [5:0] conductance;
  } rtfr_drive_type;

endpackage

//--- rtfr_readmux.sv
/*
  Registered read data selector for the register group.
  Assumes a single clock and an active high asynchronous reset.
*/
`timescale 1ns/100ps
`include "rtfr_consts.svh"

module rtfr_readmux
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       rd,
  input  wire logic [5:0] addr,
  input  wire logic [7:0] timer_count,
  input  wire logic [15:0] crc_value,
  input  wire logic [7:0] framing,
  input  wire logic [7:0] txctrl,
  input  wire logic [7:0] cw_cond,
  input  wire logic [7:0] mod_cond,
  output logic      [7:0] rdata
);

  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  // Select the addressed register
  always_comb
  begin
    unique case (addr)
      `RTFR_ADDR_TIMER:    rdata_d = timer_count;
      `RTFR_ADDR_CRC_LOW:  rdata_d = crc_value[7:0];
      `RTFR_ADDR_CRC_HIGH: rdata_d = crc_value[15:8];
      `RTFR_ADDR_FRAMING:  rdata_d = framing;
      `RTFR_ADDR_TXCTRL:   rdata_d = txctrl;
      `RTFR_ADDR_CW_COND:  rdata_d = cw_cond;
      `RTFR_ADDR_MOD_COND: rdata_d = mod_cond;
      default:             rdata_d = 8'h00;
    endcase
  end

  // Capture on a read strobe
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else if (rd)
      rdata_q <= rdata_d;
  end

  assign rdata = rdata_q;

endmodule

//--- rtfr_card.sv
/* Card side model watching the first antenna pin.
   Assumes drive is sampled on core_clk. */
`timescale 1ns/100ps
module rtfr_card
(
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire rtfr_pkg::rtfr_drive_type drive,
  output logic                        field_present
);
  import rtfr_pkg::*;
  logic       last_q;
  logic [1:0] hold_q;
  // Field seen while the first pin keeps toggling
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      hold_q <= 2'h0;
    else if (drive.first_pin != last_q)
      hold_q <= 2'h3;
    else if (hold_q != 2'h0)
      hold_q <= hold_q - 2'h1;
  // Previous pin level
  always_ff @(posedge core_clk)
    last_q <= drive.first_pin;
  assign field_present = hold_q != 2'h0;
endmodule

//--- rtfr_regs_chk.sv
/* Port checker for the framing register group.
   Assumes binding to rtfr_regs, one clock, rst async high. */
`timescale 1ns/100ps
module rtfr_regs_chk
(
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire rtfr_pkg::rtfr_req_type  host_req,
  input wire logic              [7:0] host_rdata,
  input wire logic              [7:0] timer_count,
  input wire logic             [15:0] crc_value,
  input wire logic                    crc_completion_flag,
  input wire logic                    crc_eight_bit,
  input wire logic                    reception_done,
  input wire logic                    transmission_done,
  input wire logic                    encoder_data,
  input wire logic                    external_modulation_input,
  input wire logic                    carrier_clk_phase,
  input wire logic              [2:0] receive_alignment,
  input wire logic              [2:0] transmit_last_bits,
  input wire logic                    crc_result_valid,
  input wire logic                    crc_high_valid,
  input wire rtfr_pkg::rtfr_drive_type drive
);
  import rtfr_pkg::*;
  logic [7:0] tx_q;
  logic [7:0] cw_q;
  logic [7:0] md_q;
  logic       mod_in;
  // Shadow copies of the driver registers
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      tx_q <= 8'h58;
      cw_q <= 8'h3f;
      md_q <= 8'h3f;
    end
    else if (host_req.wr)
    begin
      if (host_req.addr == 6'h11) tx_q <= host_req.wdata;
      if (host_req.addr == 6'h12) cw_q <= host_req.wdata;
      if (host_req.addr == 6'h13) md_q <= host_req.wdata;
    end
  // Selected modulator input
  assign mod_in = tx_q[6] ? (tx_q[5] ? external_modulation_input : encoder_data) : tx_q[5];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rd(a);
    host_req.rd && host_req.addr == a;
  endsequence
  sequence s_second_carrier;
    drive.second_pin == ($past(carrier_clk_phase) ^ !$past(tx_q[3]));
  endsequence
  chk_timer_view: assert property (s_rd(6'h0c) |=> host_rdata == $past(timer_count))
    else $error("timer view read wrong");
  chk_crc_low: assert property (s_rd(6'h0d) |=> host_rdata == $past(crc_value[7:0]))
    else $error("crc low read wrong");
  chk_crc_high: assert property (s_rd(6'h0e) |=> host_rdata == $past(crc_value[15:8]))
    else $error("crc high read wrong");
  chk_crc_valid: assert property (crc_high_valid == (crc_completion_flag && !crc_eight_bit) && crc_result_valid == crc_completion_flag)
    else $error("crc valid flags wrong");
  chk_align_clear: assert property (reception_done |=> receive_alignment == 3'h0)
    else $error("alignment not cleared");
  chk_last_clear: assert property (transmission_done |=> transmit_last_bits == 3'h0)
    else $error("last bits not cleared");
  chk_force_depth: assert property (mod_in && tx_q[4] |=> drive.conductance == 6'h00)
    else $error("forced depth conductance wrong");
  chk_mod_level: assert property (mod_in && !tx_q[4] |=> drive.conductance == $past(md_q[5:0]))
    else $error("modulation conductance wrong");
  chk_cw_level: assert property (!mod_in |=> drive.conductance == $past(cw_q[5:0]))
    else $error("carrier conductance wrong");
  chk_pin_one: assert property (tx_q[0] && !mod_in |=> drive.first_pin == $past(carrier_clk_phase))
    else $error("first pin carrier wrong");
  chk_pin_two: assert property (tx_q[1] && !mod_in |=> drive.second_pin == ($past(carrier_clk_phase) ^ !$past(tx_q[3])))
    else $error("second pin carrier wrong");
  chk_force_first: assert property (mod_in && tx_q[4] |=> !drive.first_pin)
    else $error("first pin not held in forced pause");
  chk_force_second: assert property (mod_in && tx_q[4] && !tx_q[2] |=> !drive.second_pin)
    else $error("second pin not held in forced pause");
  chk_cw_second: assert property (tx_q[1] && tx_q[2] |=> s_second_carrier)
    else $error("second pin continuous wave wrong");
  chk_pins_off: assert property (!tx_q[0] && !tx_q[1] |=> !drive.first_pin && !drive.second_pin)
    else $error("disabled pins not constant");
endmodule

//--- rtfr_regs_tb.sv
/* Self-checking bench for the framing register group.
   Assumes rtfr_regs, rtfr_card and rtfr_regs_chk are compiled. */
`timescale 1ns/100ps
module rtfr_regs_tb;
  import rtfr_pkg::*;
  logic           core_clk = 1'h0;
  logic           rst = 1'h1;
  logic           rx_done = 1'h0;
  logic           tx_done = 1'h0;
  logic           enc = 1'h1;
  logic           ext = 1'h0;
  logic           car = 1'h0;
  logic           flag = 1'h1;
  logic           eight = 1'h0;
  logic           seen;
  logic [7:0]     tmr = 8'h5a;
  logic [7:0]     ec;
  rtfr_req_type   req = '0;
  rtfr_drive_type drv;
  logic [7:0]     rdata;
  logic [2:0]     align;
  logic [2:0]     last;
  logic           rv;
  logic           hv;
  int             num_errors = 0;
  int             checks_done = 0;
  logic [5:0]     ra [8] = '{6'h0f, 6'h11, 6'h12, 6'h13, 6'h0c, 6'h0d, 6'h0e, 6'h20};
  logic [7:0]     re [8] = '{8'h00, 8'h58, 8'h3f, 8'h3f, 8'h5a, 8'ha7, 8'hc3, 8'h00};
  always #50 core_clk = ~core_clk;
  always @(negedge core_clk) car <= ~car;
  rtfr_regs DUT (.core_clk(core_clk), .rst(rst), .host_req(req), .host_rdata(rdata), .timer_count(tmr),
    .crc_value(16'hc3a7), .crc_completion_flag(flag), .crc_eight_bit(eight), .reception_done(rx_done),
    .transmission_done(tx_done), .encoder_data(enc), .external_modulation_input(ext), .carrier_clk_phase(car),
    .receive_alignment(align), .transmit_last_bits(last), .crc_result_valid(rv), .crc_high_valid(hv), .drive(drv));
  rtfr_card card (.core_clk(core_clk), .rst(rst), .drive(drv), .field_present(seen));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    req.rd = 1'h1;
    req.addr = a;
    @(negedge core_clk);
    req.rd = 1'h0;
    chk(rdata, exp);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req.wr = 1'h1;
    req.addr = a;
    req.wdata = d;
    @(negedge core_clk);
    req.wr = 1'h0;
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #100000;
    num_errors++;
    end_of_test;
  end
  // Main sequence
  initial
  begin
    repeat (6) @(negedge core_clk);
    rst = 1'h0;
    for (int i = 0; i < 8; i++)
      rd(ra[i], re[i]);
    tmr = 8'ha5;
    rd(6'h0c, 8'ha5);
    chk({6'h0, rv, hv}, 8'h03);
    eight = 1'h1;
    #1 chk({6'h0, rv, hv}, 8'h02);
    flag = 1'h0;
    #1 chk({6'h0, rv, hv}, 8'h00);
    wr(6'h0f, 8'hf5);
    rd(6'h0f, 8'h75);
    chk({2'h0, align, last}, 8'h3d);
    rx_done = 1'h1;
    @(negedge core_clk);
    rx_done = 1'h0;
    chk({2'h0, align, last}, 8'h05);
    tx_done = 1'h1;
    @(negedge core_clk);
    tx_done = 1'h0;
    chk({2'h0, align, last}, 8'h00);
    // Host write and end of reception in one cycle
    fork
      wr(6'h0f, 8'h77);
      begin
        @(negedge core_clk);
        rx_done = 1'h1;
        @(negedge core_clk);
        rx_done = 1'h0;
      end
    join
    chk({2'h0, align, last}, 8'h07);
    wr(6'h12, 8'h15);
    wr(6'h13, 8'h2a);
    for (int i = 0; i < 16; i++)
    begin
      enc = ~i[3];
      ext = i[3];
      wr(6'h11, {1'h0, i[1:0], i[2], i[3], i[3], 2'h3});
      @(negedge core_clk);
      ec = (i[1:0] == 2'h1 || i[1:0] == {1'h1, i[3]}) ? (i[2] ? 8'h00 : 8'h2a) : 8'h15;
      chk({2'h0, drv.conductance}, ec);
    end
    wr(6'h11, 8'h01);
    repeat (3) @(negedge core_clk);
    chk({7'h0, seen}, 8'h01);
    wr(6'h11, 8'h00);
    repeat (5) @(negedge core_clk);
    chk({7'h0, seen}, 8'h00);
    rst = 1'h1;
    @(negedge core_clk);
    chk(drv, 8'h00);
    chk(rdata, 8'h00);
    rst = 1'h0;
    rd(6'h11, 8'h58);
    rd(6'h0f, 8'h00);
    end_of_test;
  end
endmodule
bind rtfr_regs rtfr_regs_chk u_chk (.core_clk(core_clk), .rst(rst), .host_req(host_req), .host_rdata(host_rdata),
  .timer_count(timer_count), .crc_value(crc_value), .crc_completion_flag(crc_completion_flag),
  .crc_eight_bit(crc_eight_bit), .reception_done(reception_done), .transmission_done(transmission_done),
  .encoder_data(encoder_data), .external_modulation_input(external_modulation_input),
  .carrier_clk_phase(carrier_clk_phase), .receive_alignment(receive_alignment),
  .transmit_last_bits(transmit_last_bits), .crc_result_valid(crc_result_valid), .crc_high_valid(crc_high_valid),
  .drive(drive));
